/* File: hw/drp_pkg.sv */
// package: register map, field layout and population code table for the row population decoder
package drp_pkg;
   // register offsets (byte addresses on the plain config port)
   localparam logic [7:0] DRP_OFS_POPULATION = 8'h52;
   localparam logic [7:0] DRP_OFS_SYS_MGMT = 8'h70;
   localparam logic [7:0] DRP_OFS_MEM_CTRL = 8'h50;
   // field positions
   localparam int DRP_DIMM0_LSB = 0;
   localparam int DRP_DIMM1_LSB = 4;
   localparam int DRP_CODE_W = 4;
   localparam int DRP_LOCK_BIT = 4;
   localparam int DRP_FREQ_BIT = 2;
   // reset values
   localparam logic [7:0] DRP_POP_RST = 8'h00;
   localparam logic DRP_LOCK_RST = 1'b0;
   // geometry limits
   localparam int DRP_NUM_ROWS = 6;
   localparam int DRP_NUM_DIMMS = 3;
   localparam int DRP_ROW_DATA_W = 64;
   localparam int DRP_DECODED_DIMMS = 2;

   // per-side geometry: present, row bits, bank bits, column bits, size in 8 MB units
   typedef struct packed {
      logic present;
      logic [3:0] row_bits;
      logic [1:0] bank_bits;
      logic [3:0] col_bits;
      logic [5:0] size_8mb;
   } drp_side_t;

   localparam drp_side_t DRP_SIDE_NONE = '{1'b0, 4'h0, 2'h0, 4'h0, 6'h00};

   // decode one side of a population code; back selects the back side
   function automatic drp_side_t drp_decode_side(input logic [3:0] code, input logic back);
      drp_side_t s;
      s = DRP_SIDE_NONE;
      case (code)
         4'h1: s = '{1'b1, 4'hb, 2'h1, 4'h9, 6'h02};
         4'h2: s = back ? DRP_SIDE_NONE : '{1'b1, 4'hc, 2'h2, 4'h8, 6'h04};
         4'h3: s = back ? '{1'b1, 4'hb, 2'h1, 4'h9, 6'h02} : '{1'b1, 4'hc, 2'h2, 4'h8, 6'h04};
         4'h4: s = '{1'b1, 4'hc, 2'h2, 4'h8, 6'h04};
         4'h5: s = back ? DRP_SIDE_NONE : '{1'b1, 4'hc, 2'h2, 4'h9, 6'h08};
         4'h6: s = back ? '{1'b1, 4'hc, 2'h2, 4'h8, 6'h04} : '{1'b1, 4'hc, 2'h2, 4'h9, 6'h08};
         4'h7: s = '{1'b1, 4'hc, 2'h2, 4'h9, 6'h08};
         4'h9: s = back ? DRP_SIDE_NONE : '{1'b1, 4'hc, 2'h2, 4'ha, 6'h10};
         4'ha: s = back ? DRP_SIDE_NONE : '{1'b1, 4'hd, 2'h2, 4'h9, 6'h10};
         4'hb: s = back ? '{1'b1, 4'hc, 2'h2, 4'h9, 6'h08} : '{1'b1, 4'hc, 2'h2, 4'ha, 6'h10};
         4'hc: s = '{1'b1, 4'hc, 2'h2, 4'ha, 6'h10};
         4'hd: s = '{1'b1, 4'hd, 2'h2, 4'h9, 6'h10};
         4'he: s = back ? DRP_SIDE_NONE : '{1'b1, 4'hd, 2'h2, 4'ha, 6'h20};
         4'hf: s = '{1'b1, 4'hd, 2'h2, 4'ha, 6'h20};
         default: s = DRP_SIDE_NONE;
      endcase
      return s;
   endfunction : drp_decode_side
endpackage : drp_pkg

/* File: hw/drp_side_decode.sv */
// registered decode of one dimm population code into front and back row geometry
`timescale 1ns/1ps
`default_nettype none
module drp_side_decode (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // population code
   input wire logic [3:0] code,
   // decoded sides
   output drp_pkg::drp_side_t front,
   output drp_pkg::drp_side_t back
);
   import drp_pkg::*;

   typedef struct packed {
      drp_side_t front;
      drp_side_t back;
   } drp_dec_state_t;

   drp_dec_state_t st_r;
   drp_dec_state_t st_nxt;

   always_comb begin
      st_nxt.front = drp_decode_side(code, 1'b0);
      st_nxt.back = drp_decode_side(code, 1'b1);
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '{DRP_SIDE_NONE, DRP_SIDE_NONE};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign front = st_r.front;
   assign back = st_r.back;

   a_empty_code: assert property (@(posedge clock) disable iff (!rst_n)
      (code == 4'h0 || code == 4'h8) |=> (!st_r.front.present && !st_r.back.present))
      else $error("reserved or empty code enabled a row");
   a_single_back: assert property (@(posedge clock) disable iff (!rst_n)
      (code inside {4'h2, 4'h5, 4'h9, 4'ha, 4'he}) |=> (st_r.front.present && !st_r.back.present))
      else $error("single sided code enabled back row");
endmodule : drp_side_decode
`default_nettype wire

/* File: hw/drp_row_population.sv */
// row population register with lock, frequency select and per-row geometry decode
//
// Contract
// - up to six 64-bit rows, two sides on each of three dimm sockets
// - every row presents a 64-bit data width to the controller
// - population register is 8 bits at 52h, resets to 00h
// - lock bit in system management control at 70h makes the register read-only
// - bits 7:4 hold the second dimm socket population code
// - bits 3:0 hold the first dimm socket population code
// - code describes front and back sides; single-sided codes leave back row empty
// - codes decode to row, bank and column widths and capacity per side
// - frequency select bit chooses 100 MHz at 0 and 133 MHz at 1
`timescale 1ns/1ps
`default_nettype none
module drp_row_population #(
   parameter int ROWS = drp_pkg::DRP_NUM_ROWS,
   parameter int ROW_W = drp_pkg::DRP_ROW_DATA_W
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // third socket code, held elsewhere
   input wire logic [3:0] dimm2_code,
   // decoded geometry, one bit or field per row; data width is one field shared by all rows
   output logic [5:0] row_present,
   output logic [23:0] row_addr_bits,
   output logic [11:0] row_bank_bits,
   output logic [23:0] row_col_bits,
   output logic [35:0] row_size_8mb,
   output logic [6:0] row_data_width,
   // frequency and lock state
   output logic mem_freq_133,
   output logic cfg_locked
);
   import drp_pkg::*;

   initial begin
      if (ROWS != DRP_NUM_ROWS || ROW_W != DRP_ROW_DATA_W) begin
         $error("drp_row_population: only six 64-bit rows are supported");
      end
   end

   typedef struct packed {
      logic [7:0] pop;
      logic lock;
      logic freq;
      logic [7:0] rdata;
      logic [5:0] present;
      logic [23:0] addr_bits;
      logic [11:0] bank_bits;
      logic [23:0] col_bits;
      logic [35:0] size;
   } drp_state_t;

   drp_state_t st_r;
   drp_state_t st_nxt;
   drp_side_t side_f [DRP_NUM_DIMMS];
   drp_side_t side_b [DRP_NUM_DIMMS];
   logic [3:0] codes [DRP_NUM_DIMMS];

   assign codes[0] = st_r.pop[DRP_DIMM0_LSB +: DRP_CODE_W];
   assign codes[1] = st_r.pop[DRP_DIMM1_LSB +: DRP_CODE_W];
   assign codes[2] = dimm2_code;

   // one decoder per socket; each yields the front and back row
   genvar g;
   generate
      for (g = 0; g < DRP_NUM_DIMMS; g++) begin : g_dimm
         drp_side_decode u_dec (
            .clock(clock),
            .rst_n(rst_n),
            .code(codes[g]),
            .front(side_f[g]),
            .back(side_b[g])
         );
      end
   endgenerate

   always_comb begin
      st_nxt = st_r;
      // register writes; lock is write-once-to-one until reset
      if (reg_wr) begin
         if (reg_addr == DRP_OFS_POPULATION && !st_r.lock) begin
            st_nxt.pop = reg_wdata;
         end
         if (reg_addr == DRP_OFS_SYS_MGMT && reg_wdata[DRP_LOCK_BIT]) begin
            st_nxt.lock = 1'b1;
         end
         if (reg_addr == DRP_OFS_MEM_CTRL) begin
            st_nxt.freq = reg_wdata[DRP_FREQ_BIT];
         end
      end
      // read data stands one cycle after the strobe, zero otherwise
      st_nxt.rdata = 8'h00;
      if (reg_rd) begin
         case (reg_addr)
            DRP_OFS_POPULATION: st_nxt.rdata = st_r.pop;
            DRP_OFS_SYS_MGMT: st_nxt.rdata = 8'(st_r.lock) << DRP_LOCK_BIT;
            DRP_OFS_MEM_CTRL: st_nxt.rdata = 8'(st_r.freq) << DRP_FREQ_BIT;
            default: st_nxt.rdata = 8'h00;
         endcase
      end
      // row 2k is the front side of socket k, row 2k+1 the back
      for (int k = 0; k < DRP_NUM_DIMMS; k++) begin
         st_nxt.present[2*k] = side_f[k].present;
         st_nxt.present[2*k+1] = side_b[k].present;
         st_nxt.addr_bits[8*k +: 4] = side_f[k].row_bits;
         st_nxt.addr_bits[8*k+4 +: 4] = side_b[k].row_bits;
         st_nxt.bank_bits[4*k +: 2] = side_f[k].bank_bits;
         st_nxt.bank_bits[4*k+2 +: 2] = side_b[k].bank_bits;
         st_nxt.col_bits[8*k +: 4] = side_f[k].col_bits;
         st_nxt.col_bits[8*k+4 +: 4] = side_b[k].col_bits;
         st_nxt.size[12*k +: 6] = side_f[k].size_8mb;
         st_nxt.size[12*k+6 +: 6] = side_b[k].size_8mb;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '{DRP_POP_RST, DRP_LOCK_RST, 1'b0, 8'h00, 6'h00, 24'h0, 12'h0, 24'h0, 36'h0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign reg_rdata = st_r.rdata;
   assign row_present = st_r.present;
   assign row_addr_bits = st_r.addr_bits;
   assign row_bank_bits = st_r.bank_bits;
   assign row_col_bits = st_r.col_bits;
   assign row_size_8mb = st_r.size;
   assign row_data_width = 7'(ROW_W);
   assign mem_freq_133 = st_r.freq;
   assign cfg_locked = st_r.lock;

   a_lock_holds: assert property (@(posedge clock) disable iff (!rst_n)
      (st_r.lock && reg_wr && reg_addr == DRP_OFS_POPULATION) |=> $stable(st_r.pop))
      else $error("population changed while locked");
   a_write_takes: assert property (@(posedge clock) disable iff (!rst_n)
      (!st_r.lock && reg_wr && reg_addr == DRP_OFS_POPULATION) |=> st_r.pop == $past(reg_wdata))
      else $error("unlocked write not stored");
   a_read_back: assert property (@(posedge clock) disable iff (!rst_n)
      (reg_rd && reg_addr == DRP_OFS_POPULATION) |=> reg_rdata == $past(st_r.pop))
      else $error("read data mismatch");
   a_lock_sticky: assert property (@(posedge clock) disable iff (!rst_n)
      st_r.lock |=> st_r.lock)
      else $error("lock dropped without reset");
   a_freq_sel: assert property (@(posedge clock) disable iff (!rst_n)
      (reg_wr && reg_addr == DRP_OFS_MEM_CTRL) |=> mem_freq_133 == $past(reg_wdata[DRP_FREQ_BIT]))
      else $error("frequency select not taken");
   a_dimm0_empty: assert property (@(posedge clock) disable iff (!rst_n)
      (codes[0] == 4'h0 || codes[0] == 4'h8) |-> ##2 (row_present[1:0] == 2'b00 || codes[0] != $past(codes[0], 2)))
      else $error("empty socket enabled rows");
   a_dimm1_code: assert property (@(posedge clock) disable iff (!rst_n)
      (codes[1] == 4'h3) ##1 (codes[1] == 4'h3) |=> (row_col_bits[11:8] == 4'h8 && row_col_bits[15:12] == 4'h9))
      else $error("mixed code column widths wrong");
   a_dimm0_row: assert property (@(posedge clock) disable iff (!rst_n)
      (codes[0] == 4'hf) ##1 (codes[0] == 4'hf) |=> (row_addr_bits[3:0] == 4'hd && row_present[1:0] == 2'b11))
      else $error("code f geometry wrong");
endmodule : drp_row_population
`default_nettype wire

/* File: tb/drp_dimm_model.sv */
// third dimm socket model: reports the code of the module fitted there
`timescale 1ns/1ps
`default_nettype none
module drp_dimm_model (
   // clock
   input wire logic clock,
   // module fitted by the bench
   input wire logic [3:0] fitted,
   // code seen by the controller
   output logic [3:0] dimm2_code
);
   // code is settled a cycle after a swap, like a strap read at configuration time
   always_ff @(posedge clock) begin
      dimm2_code <= fitted;
   end
endmodule : drp_dimm_model
`default_nettype wire

/* File: tb/tb_dram_row_population_decode.sv */
// testbench for the row population register and geometry decode
`timescale 1ns/1ps
`default_nettype none
module tb_dram_row_population_decode;
   import drp_pkg::*;
   localparam drp_side_t GT[7] = '{DRP_SIDE_NONE, '{1'b1, 4'hb, 2'h1, 4'h9, 6'h02},
      '{1'b1, 4'hc, 2'h2, 4'h8, 6'h04}, '{1'b1, 4'hc, 2'h2, 4'h9, 6'h08}, '{1'b1, 4'hc, 2'h2, 4'ha, 6'h10},
      '{1'b1, 4'hd, 2'h2, 4'h9, 6'h10}, '{1'b1, 4'hd, 2'h2, 4'ha, 6'h20}};
   // geometry index per code, one nibble each, front and back
   localparam logic [63:0] FR = 64'h6654_4540_3332_2210;
   localparam logic [63:0] BK = 64'h6054_3000_3202_1010;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
   logic reg_wr = 1'b0, reg_rd = 1'b0, rd_seen = 1'b0;
   logic [3:0] fitted = 4'h0, dimm2_code;
   logic [5:0] row_present;
   logic [23:0] row_addr_bits, row_col_bits;
   logic [11:0] row_bank_bits;
   logic [35:0] row_size_8mb;
   logic [6:0] row_data_width;
   logic mem_freq_133, cfg_locked;
   logic [7:0] pop, expq[$];
   int mismatches = 0, checked = 0;

   drp_dimm_model i_dimm (.clock(clock), .fitted(fitted), .dimm2_code(dimm2_code));
   drp_row_population i_dut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dimm2_code(dimm2_code),
      .row_present(row_present), .row_addr_bits(row_addr_bits), .row_bank_bits(row_bank_bits),
      .row_col_bits(row_col_bits), .row_size_8mb(row_size_8mb), .row_data_width(row_data_width),
      .mem_freq_133(mem_freq_133), .cfg_locked(cfg_locked));

   always #2.5 clock = ~clock;

   task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // read data stands only in the cycle after the strobe, zero otherwise
   always @(posedge clock) begin
      if (rd_seen) chk(reg_rdata, expq.pop_front());
      else chk(reg_rdata, 36'h0);
      rd_seen = reg_rd;
   end

   // one bus cycle; strobes stay up so calls run back to back
   task automatic op(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_wr <= w;
      reg_rd <= !w;
      reg_addr <= a;
      reg_wdata <= w ? d : 8'h00;
      if (!w) expq.push_back(d);
   endtask : op

   task automatic idle();
      @(posedge clock);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
   endtask : idle

   function automatic drp_side_t es(input logic [3:0] c, input logic b);
      return GT[b ? BK[4*c+:4] : FR[4*c+:4]];
   endfunction : es

   task automatic geo(input logic [11:0] codes);
      repeat (4) @(posedge clock);
      #1;
      for (int r = 0; r < 6; r++) chk({row_present[r], row_addr_bits[4*r+:4], row_bank_bits[2*r+:2],
         row_col_bits[4*r+:4], row_size_8mb[6*r+:6]}, 36'(es(codes[4*(r/2)+:4], r[0])));
   endtask : geo

   task automatic close_out();
      $display("counts: checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : close_out

   initial begin
      #50000;
      mismatches++;
      close_out();
   end

   initial begin
      void'($urandom(27));
      repeat (6) @(posedge clock);
      rst_n <= 1'b1;
      op(0, DRP_OFS_POPULATION, DRP_POP_RST);
      op(0, DRP_OFS_SYS_MGMT, 8'h00);
      op(1, 8'h61, 8'h33);
      op(0, 8'h61, 8'h00);
      idle();
      geo(12'h000);
      chk(row_data_width, 36'd64);
      $display("reset and unmapped done");
      op(1, DRP_OFS_MEM_CTRL, 8'h04);
      op(0, DRP_OFS_MEM_CTRL, 8'h04);
      idle();
      #1 chk(mem_freq_133, 36'h1);
      // software drops to 100 MHz when too many modules are fitted
      op(1, DRP_OFS_MEM_CTRL, 8'h00);
      idle();
      #1 chk(mem_freq_133, 36'h0);
      $display("frequency select done");
      for (int c = 0; c < 16; c++) begin
         pop = {4'(c), 4'($urandom)};
         fitted <= 4'(15 - c);
         op(1, DRP_OFS_POPULATION, pop);
         op(0, DRP_OFS_POPULATION, pop);
         idle();
         geo({4'(15 - c), pop});
      end
      $display("code table done");
      op(1, DRP_OFS_SYS_MGMT, 8'h10);
      op(1, DRP_OFS_POPULATION, ~pop);
      op(0, DRP_OFS_POPULATION, pop);
      op(1, DRP_OFS_SYS_MGMT, 8'h00);
      op(0, DRP_OFS_SYS_MGMT, 8'h10);
      idle();
      #1 chk(cfg_locked, 36'h1);
      geo({fitted, pop});
      $display("lock done");
      // only a reset clears the lock and the population
      @(posedge clock);
      rst_n <= 1'b0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      op(0, DRP_OFS_POPULATION, DRP_POP_RST);
      idle();
      #1 chk(cfg_locked, 36'h0);
      geo({fitted, 8'h00});
      $display("mid reset done");
      close_out();
   end
endmodule : tb_dram_row_population_decode
`default_nettype wire
